/* File: common/egr_pkg.sv */
// Notes on behaviour
// - Mode 0 turns the gear off; reset default
// - Mode 1: master frequency times numerator/denominator
// - Mode 2: numerator from percentage, stored denominator
// - Mode 3: stored numerator, denominator from percentage
// - Numerator -300..300, denominator 0.01..300, both 1.00
// - Endpoints 0..100, defaults 1.20 and 0.80
// - Percentage term used only in modes 2, 3
// - Gear output used only when a selector picks it
// - Selector two = 3 adds fixed frequency offset
// - Fixed offset picked from bank by three inputs
// - Selector two = 5 adds keypad potentiometer offset
// - Status shows measured repetition frequency
// - Status shows final geared plus offset frequency
package egr_pkg;

    typedef logic signed [31:0] freq_type;

    typedef enum logic [1:0] {
        GEAR_OFF = 2'h0,
        GEAR_FIXED = 2'h1,
        GEAR_ANA_NUM = 2'h2,
        GEAR_ANA_DEN = 2'h3
    } gear_mode_type;

    // Factors are in hundredths, percentage in hundredths of a percent
    typedef struct packed {
        gear_mode_type mode;
        logic signed [15:0] num;
        logic signed [15:0] den;
        logic signed [15:0] ana_full;
        logic signed [15:0] ana_zero;
        logic [7:0] src1;
        logic [7:0] src2;
    } cfg_type;

    // Register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_NUM = 8'h04;
    localparam logic [7:0] OFF_DEN = 8'h08;
    localparam logic [7:0] OFF_ANA_FULL = 8'h0c;
    localparam logic [7:0] OFF_ANA_ZERO = 8'h10;
    localparam logic [7:0] OFF_SRC1 = 8'h14;
    localparam logic [7:0] OFF_SRC2 = 8'h18;
    localparam logic [7:0] OFF_MEAS = 8'h1c;
    localparam logic [7:0] OFF_REF = 8'h20;
    localparam logic [7:0] OFF_FIXED = 8'h40;
    localparam logic [7:0] OFF_FIXED_END = 8'h5c;
    localparam int FIXED_COUNT = 8;
    // Bank word index sits just above the byte-lane bits
    localparam int BANK_IDX_LSB = 2;
    localparam int BANK_IDX_W = 3;

    // Limits and defaults in hundredths; selector defaults are codes
    localparam logic signed [31:0] NUM_MIN = -32'sd30000;
    localparam logic signed [31:0] NUM_MAX = 32'sd30000;
    localparam logic signed [31:0] DEN_MIN = 32'sd1;
    localparam logic signed [31:0] DEN_MAX = 32'sd30000;
    localparam logic signed [31:0] ANA_MIN = 32'sd0;
    localparam logic signed [31:0] ANA_MAX = 32'sd10000;
    localparam logic signed [31:0] PCT_FULL = 32'sd10000;
    localparam logic signed [15:0] NUM_RST = 16'sd100;
    localparam logic signed [15:0] DEN_RST = 16'sd100;
    localparam logic signed [15:0] ANA_FULL_RST = 16'sd120;
    localparam logic signed [15:0] ANA_ZERO_RST = 16'sd80;
    localparam logic [7:0] SRC1_RST = 8'h01;
    localparam logic [7:0] SRC2_RST = 8'h05;

    // Selector codes
    localparam logic [7:0] SRC_FIXED = 8'h03;
    localparam logic [7:0] SRC_POT = 8'h05;
    localparam logic [7:0] SRC_GEAR = 8'h28;

    // Saturation bounds for 32-bit frequencies
    localparam logic signed [63:0] SAT_MAX = 64'sh000000007fffffff;
    localparam logic signed [63:0] SAT_MIN = -64'sh0000000080000000;

endpackage

/* File: hw/electronic_gear_ratio.sv */
`timescale 1ns/1ps
module electronic_gear_ratio (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire egr_pkg::freq_type rep_freq_i,
    input wire logic signed [15:0] percent_i,
    input wire egr_pkg::freq_type pot_freq_i,
    input wire logic update_i,
    input wire logic [2:0] fixed_sel_i,
    output egr_pkg::freq_type gear_freq_o,
    output egr_pkg::freq_type ref_freq_o,
    output logic out_valid_o
);
    import egr_pkg::*;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Clamp into a signed range
    function automatic logic signed [31:0] clampv(
        input logic signed [31:0] v, input logic signed [31:0] lo,
        input logic signed [31:0] hi);
        logic signed [31:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // Saturate a wide result; wrapping would reverse the motor
    function automatic logic signed [31:0] sat32(
        input logic signed [63:0] v);
        logic signed [31:0] r;
        r = v[31:0];
        if (v > SAT_MAX) begin
            r = SAT_MAX[31:0];
        end else if (v < SAT_MIN) begin
            r = SAT_MIN[31:0];
        end
        return r;
    endfunction

    // Sign-extend a 16-bit setting to a bus word
    function automatic logic [31:0] sext16(input logic signed [15:0] v);
        logic [31:0] r;
        r = {{16{v[15]}}, v};
        return r;
    endfunction

    // Zero-extend a selector byte to a bus word
    function automatic logic [31:0] zext8(input logic [7:0] v);
        logic [31:0] r;
        r = {24'h0, v};
        return r;
    endfunction

    // Straight line between the endpoints; kept signed so that a
    // falling slope (full endpoint below zero endpoint) still works
    function automatic logic signed [31:0] interp(
        input logic signed [31:0] lo, input logic signed [31:0] hi,
        input logic signed [31:0] pct);
        logic signed [31:0] r;
        r = lo + ((hi - lo) * pct) / PCT_FULL;
        return r;
    endfunction

    cfg_type cfg;
    gear_mode_type gear_mode;
    logic signed [15:0] numerator;
    logic signed [15:0] denominator;
    logic signed [15:0] end_full;
    logic signed [15:0] end_zero;
    logic [7:0] source_one;
    logic [7:0] source_two;

    // Settings gathered into one word for the datapath
    assign cfg = {gear_mode, numerator, denominator, end_full, end_zero,
        source_one, source_two};

    freq_type fixed_bank [FIXED_COUNT];
    freq_type meas_freq;
    logic [2:0] sel_meta;
    logic [2:0] sel_sync;
    logic [31:0] rd_mux;

    // Bus decode
    wire access = wb_cyc_i & wb_stb_i;
    wire commit = access & wb_we_i & wb_ack_o;
    wire [31:0] cfg_mode_w = {30'h0, cfg.mode};
    wire [31:0] num_w = sext16(cfg.num);
    wire [31:0] den_w = sext16(cfg.den);
    wire [31:0] full_w = sext16(cfg.ana_full);
    wire [31:0] zero_w = sext16(cfg.ana_zero);
    wire [31:0] src1_w = zext8(cfg.src1);
    wire [31:0] src2_w = zext8(cfg.src2);
    wire in_bank = (wb_adr_i >= OFF_FIXED) && (wb_adr_i <= OFF_FIXED_END)
        && (wb_adr_i[BANK_IDX_LSB-1:0] == '0);
    wire [BANK_IDX_W-1:0] bank_idx = wb_adr_i[BANK_IDX_LSB +: BANK_IDX_W];

    // One strobe per register, so each write process stays short
    wire hit_mode = commit && (wb_adr_i == OFF_MODE);
    wire hit_num = commit && (wb_adr_i == OFF_NUM);
    wire hit_den = commit && (wb_adr_i == OFF_DEN);
    wire hit_full = commit && (wb_adr_i == OFF_ANA_FULL);
    wire hit_zero = commit && (wb_adr_i == OFF_ANA_ZERO);
    wire hit_src1 = commit && (wb_adr_i == OFF_SRC1);
    wire hit_src2 = commit && (wb_adr_i == OFF_SRC2);
    wire hit_bank = commit && in_bank;

    // Percentage clamped to 0..100 %, then interpolated
    wire signed [31:0] pct_c = clampv(32'(percent_i), ANA_MIN, PCT_FULL);
    wire signed [31:0] var_term = interp(signed'(zero_w),
        signed'(full_w), pct_c);

    // Pick numerator and denominator by mode
    wire signed [31:0] eff_num = (cfg.mode == GEAR_ANA_NUM) ? var_term
        : signed'(num_w);
    wire signed [31:0] den_pick = (cfg.mode == GEAR_ANA_DEN) ? var_term
        : signed'(den_w);
    // A zero endpoint would divide by zero; hold the smallest step
    wire signed [31:0] eff_den = clampv(den_pick, DEN_MIN, DEN_MAX);

    // Signed product keeps the numerator's sign
    wire signed [63:0] gear_prod = 64'(rep_freq_i)
        * 64'(eff_num);
    wire signed [63:0] gear_quot = gear_prod / 64'(eff_den);
    wire signed [31:0] gear_c = (cfg.mode == GEAR_OFF) ? 32'sd0
        : sat32(gear_quot);

    // Reference frequency channel sum
    wire signed [63:0] base1 = (cfg.src1 == SRC_GEAR) ? 64'(gear_c)
        : 64'sd0;
    wire signed [63:0] base2 = (cfg.src2 == SRC_GEAR) ? 64'(gear_c)
        : 64'sd0;
    wire signed [31:0] fixed_pick = fixed_bank[sel_sync];
    wire signed [63:0] offs = (cfg.src2 == SRC_FIXED)
        ? 64'(fixed_pick)
        : (cfg.src2 == SRC_POT) ? 64'(pot_freq_i) : 64'sd0;
    wire signed [31:0] final_c = sat32(base1 + base2
        + offs);

    // Changeover inputs come from pins; two stages before use
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            sel_meta <= 3'h0;
            sel_sync <= 3'h0;
        end else begin
            sel_meta <= fixed_sel_i;
            sel_sync <= sel_meta;
        end
    end

    // Classic single-cycle ack; drops the cycle after it rises
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= access & ~wb_ack_o;
            if (access & ~wb_ack_o) begin
                wb_dat_o <= wb_we_i ? 32'h0 : rd_mux;
            end
        end
    end

    // Read selection; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0;
        if (in_bank) begin
            rd_mux = fixed_bank[bank_idx];
        end else begin
            case (wb_adr_i)
                OFF_MODE: rd_mux = cfg_mode_w;
                OFF_NUM: rd_mux = num_w;
                OFF_DEN: rd_mux = den_w;
                OFF_ANA_FULL: rd_mux = full_w;
                OFF_ANA_ZERO: rd_mux = zero_w;
                OFF_SRC1: rd_mux = src1_w;
                OFF_SRC2: rd_mux = src2_w;
                OFF_MEAS: rd_mux = meas_freq;
                OFF_REF: rd_mux = ref_freq_o;
                default: rd_mux = 32'h0;
            endcase
        end
    end

    // Merged write values; numerator, denominator and endpoints clamped
    wire [31:0] wr_num = clampv(merge(num_w, wb_dat_i, wb_sel_i),
        NUM_MIN, NUM_MAX);
    wire [31:0] wr_den = clampv(merge(den_w, wb_dat_i, wb_sel_i),
        DEN_MIN, DEN_MAX);
    wire [31:0] wr_full = clampv(merge(full_w, wb_dat_i, wb_sel_i),
        ANA_MIN, ANA_MAX);
    wire [31:0] wr_zero = clampv(merge(zero_w, wb_dat_i, wb_sel_i),
        ANA_MIN, ANA_MAX);
    wire [31:0] wr_mode = merge(cfg_mode_w, wb_dat_i, wb_sel_i);
    wire [31:0] wr_src1 = merge(src1_w, wb_dat_i, wb_sel_i);
    wire [31:0] wr_src2 = merge(src2_w, wb_dat_i, wb_sel_i);
    wire [31:0] wr_bank = merge(fixed_bank[bank_idx], wb_dat_i, wb_sel_i);

    // Gear mode; writes land on the edge the master sees ack
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            gear_mode <= GEAR_OFF;
        end else if (hit_mode) begin
            gear_mode <= gear_mode_type'(wr_mode[1:0]);
        end
    end

    // Numerator; clamped on the way in, never refused
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            numerator <= NUM_RST;
        end else if (hit_num) begin
            numerator <= wr_num[15:0];
        end
    end

    // Denominator; the clamp keeps it at one step or more
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            denominator <= DEN_RST;
        end else if (hit_den) begin
            denominator <= wr_den[15:0];
        end
    end

    // Factor at full percentage
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            end_full <= ANA_FULL_RST;
        end else if (hit_full) begin
            end_full <= wr_full[15:0];
        end
    end

    // Factor at zero percentage
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            end_zero <= ANA_ZERO_RST;
        end else if (hit_zero) begin
            end_zero <= wr_zero[15:0];
        end
    end

    // Reference source selectors; any code is kept as written
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            source_one <= SRC1_RST;
            source_two <= SRC2_RST;
        end else begin
            if (hit_src1) begin
                source_one <= wr_src1[7:0];
            end
            if (hit_src2) begin
                source_two <= wr_src2[7:0];
            end
        end
    end

    // Fixed frequency bank
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < FIXED_COUNT; i++) begin
                fixed_bank[i] <= 32'sh0;
            end
        end else if (hit_bank) begin
            fixed_bank[bank_idx] <= wr_bank;
        end
    end

    // Outputs refresh on each update tick, no restart needed
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            meas_freq <= 32'sh0;
            gear_freq_o <= 32'sh0;
            ref_freq_o <= 32'sh0;
            out_valid_o <= 1'b0;
        end else begin
            out_valid_o <= update_i;
            if (update_i) begin
                meas_freq <= rep_freq_i;
                gear_freq_o <= gear_c;
                ref_freq_o <= final_c;
            end
        end
    end

endmodule

/* File: test/egr_properties.sv */
`timescale 1ns/1ps
module egr_properties (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire egr_pkg::freq_type rep_freq_i,
    input wire logic update_i,
    input wire egr_pkg::freq_type gear_freq_o,
    input wire egr_pkg::freq_type ref_freq_o,
    input wire logic out_valid_o
);
    import egr_pkg::*;
    freq_type meas_q;
    // A request is taken only while no ack is pending
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd = req && !wb_we_i;
    // Shadow of the measured status, as the bus would see it
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) meas_q <= '0;
        else if (update_i) meas_q <= rep_freq_i;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    a_ack_after_req: assert property (req |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (!req |=> !wb_ack_o)
        else $error("ack without request");
    a_valid_follows: assert property (update_i |=> out_valid_o)
        else $error("valid missing after update");
    a_valid_cause: assert property (
        out_valid_o |-> $past(update_i))
        else $error("valid without update");
    a_outputs_hold: assert property (!update_i |=>
        $stable(ref_freq_o) && $stable(gear_freq_o))
        else $error("outputs moved without update");
    a_meas_read: assert property (rd && wb_adr_i == OFF_MEAS
        |=> wb_dat_o == $past(meas_q))
        else $error("measured status wrong");
    a_ref_read: assert property (rd && wb_adr_i == OFF_REF
        |=> wb_dat_o == $past(ref_freq_o))
        else $error("final status wrong");
    c_update: cover property (update_i ##1 out_valid_o);
    c_ref_read: cover property (rd && wb_adr_i == OFF_REF);
    c_write: cover property (req && wb_we_i);
endmodule
bind electronic_gear_ratio egr_properties i_egr_properties (.clk_sys_i,
    .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
    .wb_ack_o, .rep_freq_i, .update_i, .gear_freq_o, .ref_freq_o,
    .out_valid_o);

/* File: test/master_drive_model.sv */
`timescale 1ns/1ps
module master_drive_model (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire egr_pkg::freq_type target_i,
    output egr_pkg::freq_type rep_freq_o,
    output logic update_o
);
    import egr_pkg::*;
    logic [1:0] div;
    // Slow control tick every fourth cycle; frequency follows the target every cycle
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            div <= 2'h0;
            update_o <= 1'b0;
            rep_freq_o <= '0;
        end else begin
            div <= div + 2'h1;
            update_o <= (div == 2'h3);
            rep_freq_o <= target_i;
        end
    end
endmodule

/* File: test/electronic_gear_ratio_tb_top.sv */
`timescale 1ns/1ps
module electronic_gear_ratio_tb_top;
    import egr_pkg::*;
    logic clk_sys_i = 0, nrst_i = 0, cyc = 0, stb = 0, we = 0;
    logic wb_ack_o, out_valid_o, update_i;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat = 32'h0, wb_dat_o, q;
    logic signed [15:0] pct = 16'sh0;
    logic [2:0] fsel = 3'h0;
    freq_type target = '0, pot = '0, rep_freq_i, gear_freq_o, ref_freq_o;
    int fails = 0, checked = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    master_drive_model i_master_drive_model (.clk_sys_i, .nrst_i,
        .target_i(target), .rep_freq_o(rep_freq_i), .update_o(update_i));
    electronic_gear_ratio i_electronic_gear_ratio (.clk_sys_i, .nrst_i,
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o,
        .rep_freq_i, .percent_i(pct), .pot_freq_i(pot), .update_i,
        .fixed_sel_i(fsel), .gear_freq_o, .ref_freq_o, .out_valid_o);
    // Classic cycle: hold everything until ack is seen at an edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Two ticks, so the second one surely saw the new settings
    task settle;
        repeat (2) begin
            @(posedge clk_sys_i);
            while (out_valid_o !== 1'b1) @(posedge clk_sys_i);
        end
    endtask
    task t_defaults;
        logic [7:0] a [7];
        logic [31:0] e [7];
        a = '{OFF_MODE, OFF_NUM, OFF_DEN, OFF_ANA_FULL, OFF_ANA_ZERO,
            OFF_SRC1, OFF_SRC2};
        e = '{32'h0, 32'h64, 32'h64, 32'h78, 32'h50, 32'h1, 32'h5};
        for (int i = 0; i < 7; i++) begin
            bus(0, a[i], 32'h0);
            chk(q, e[i]);
        end
        $display("test defaults done");
    endtask
    task t_fixed;
        target <= 32'sd1000;
        bus(1, OFF_MODE, 32'h1);
        bus(1, OFF_NUM, 32'h12c);
        bus(1, OFF_DEN, 32'hc8);
        bus(1, OFF_SRC1, 32'h28);
        bus(1, OFF_SRC2, 32'h0);
        settle;
        chk(gear_freq_o, 32'd1500);
        chk(ref_freq_o, 32'd1500);
        bus(1, OFF_SRC1, 32'h1);
        settle;
        chk(ref_freq_o, 32'd0);
        chk(gear_freq_o, 32'd1500);
        $display("test fixed done");
    endtask
    task t_limits;
        bus(1, OFF_NUM, 32'h9c40);
        bus(0, OFF_NUM, 32'h0);
        chk(q, 32'h7530);
        bus(1, OFF_DEN, 32'h0);
        bus(0, OFF_DEN, 32'h0);
        chk(q, 32'h1);
        bus(1, OFF_DEN, 32'h64);
        bus(1, OFF_NUM, 32'hffff8ad0);
        bus(1, OFF_SRC1, 32'h28);
        target <= 32'sd100000000;
        settle;
        chk(gear_freq_o, 32'h80000000);
        $display("test limits done");
    endtask
    task t_analog;
        target <= 32'sd1000;
        pct <= 16'sd7500;
        bus(1, OFF_NUM, 32'h64);
        bus(1, OFF_DEN, 32'hc8);
        bus(1, OFF_MODE, 32'h2);
        settle;
        chk(gear_freq_o, 32'd550);
        pct <= 16'sd0;
        bus(1, OFF_DEN, 32'h64);
        bus(1, OFF_MODE, 32'h3);
        settle;
        chk(gear_freq_o, 32'd1250);
        // Falling slope: full 0.50, zero 1.50, half way gives 1.00
        bus(1, OFF_ANA_FULL, 32'h32);
        bus(1, OFF_ANA_ZERO, 32'h96);
        bus(1, OFF_MODE, 32'h2);
        pct <= 16'sd5000;
        settle;
        chk(gear_freq_o, 32'd1000);
        $display("test analog done");
    endtask
    task t_offset;
        bus(1, OFF_MODE, 32'h0);
        bus(1, OFF_SRC2, 32'h3);
        bus(1, OFF_FIXED + 8'h14, 32'd777);
        fsel <= 3'h5;
        pot <= 32'sd333;
        settle;
        chk(gear_freq_o, 32'd0);
        chk(ref_freq_o, 32'd777);
        bus(1, OFF_SRC2, 32'h5);
        settle;
        chk(ref_freq_o, 32'd333);
        bus(0, OFF_MEAS, 32'h0);
        chk(q, 32'd1000);
        bus(0, OFF_REF, 32'h0);
        chk(q, 32'd333);
        bus(0, 8'h30, 32'h0);
        chk(q, 32'h0);
        $display("test offset done");
    endtask
    task wrap_up;
        $display("compares %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Whole sequence needs a few hundred cycles; this is far beyond it
    initial begin
        #200000;
        fails++;
        wrap_up;
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        t_defaults;
        t_fixed;
        t_limits;
        t_analog;
        t_offset;
        wrap_up;
    end
endmodule
